// >>> core/pciw_pkg.sv
/*
 pciw_pkg: constants shared by both ends of the inbound window bridge link.
 assumes: compiled before every other file of the block.
*/
`default_nettype none
package pciw_pkg;
	localparam int NWIN = 6;
	// link command codes
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_MEM_WRI = 4'hf;
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	// host_window_base field layout
	localparam int BASE_ADDR_LSB = 4;
	localparam int READAHEAD_BIT = 3;
	localparam logic [1:0] SPACE_TYPE_MEM = 2'h0;
	localparam logic SPACE_IND_32 = 1'b0;
	// configuration dword index of host_window0_base
	localparam logic [5:0] CFG_BASE0_IDX = 6'h04;
	// window reset values
	localparam logic [31:0] MSK_RST [0:NWIN-1] = '{32'hff80_0008, 32'hffc0_0000, 32'hff80_0000,
		32'hff80_0008, 32'hff80_0008, 32'hff80_0008};
	localparam logic [31:0] TRL_RST [0:NWIN-1] = '{32'h0080_0000, 32'h0180_0000, 32'h0280_0000,
		32'h8000_0000, 32'ha000_0000, 32'he000_0000};
	localparam logic [27:0] BASE_RST = 28'h000_0000;
	// local register word indices
	localparam logic [5:0] IDX_MSK0 = 6'h00;
	localparam logic [5:0] IDX_TRL0 = 6'h08;
	localparam logic [5:0] IDX_MST_BASE = 6'h10;
	localparam logic [5:0] IDX_MST_MASK = 6'h11;
	localparam logic [5:0] IDX_MST_BUS = 6'h12;
	localparam logic [5:0] IDX_STATUS = 6'h13;
	localparam logic [31:0] MST_BASE_RST = 32'h4000_0000;
	localparam logic [31:0] MST_MASK_RST = 32'hf000_0000;
	localparam logic [31:0] MST_BUS_RST = 32'h0000_0000;
	// speed strap encoding
	localparam logic SPEED_33 = 1'b0;
	localparam logic SPEED_66 = 1'b1;
	// link clock made by the host end
	localparam int SYS_PERIOD_NS = 100;
	localparam int LINK_PERIOD_NS = 800;
	localparam logic [3:0] LINK_HALF_CYC = 4'((LINK_PERIOD_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS));
endpackage
`default_nettype wire

// >>> core/pciw_link_if.sv
/*
 pciw_link_if: the bus link between the host end and the device end.
 assumes: host drives link clock and request; device returns ack, hit and read data.
*/
`timescale 1ns/1ns
`default_nettype none
interface pciw_link_if;
	logic pclk;
	logic frame;
	logic idsel;
	logic [3:0] cmd;
	logic [3:0] be;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic ack;
	logic hit;
	logic [31:0] rdata;
	modport dev (input pclk, input frame, input idsel, input cmd, input be, input addr, input wdata,
		output ack, output hit, output rdata);
	modport host (output pclk, output frame, output idsel, output cmd, output be, output addr,
		output wdata, input ack, input hit, input rdata);
endinterface
`default_nettype wire

// >>> core/pciw_window.sv
/*
 pciw_window: match and translate one inbound window.
 assumes: pure combinational; caller resolves priority between windows.
*/
`timescale 1ns/1ns
`default_nettype none
module pciw_window
(
	input wire logic [31:0] bus_addr,
	input wire logic [27:0] base,
	input wire logic [31:0] mask,
	input wire logic [31:0] trl,
	output logic hit,
	output logic [31:0] local_addr
);
	logic [31:0] sel;

	always_comb
	begin
		sel = {mask[31:4], 4'h0};
		// an all-clear mask would match every address, so it disables the window
		hit = (mask[31:4] != 28'h0) && (((bus_addr[31:4] ^ base) & mask[31:4]) == 28'h0); // [RULE22]
		local_addr = (bus_addr & ~sel) | (trl & sel); // [RULE23]
	end
endmodule // pciw_window
`default_nettype wire

// >>> core/pciw_device.sv
/*
 pciw_device: bridge end with six inbound windows, master map and local registers.
 assumes: APB master on sys_clk; fabric answers on sys_clk; link driven by the host end.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// (RULE1) claim local requests only inside master map
// (RULE2) claim bus accesses only inside a window
// (RULE3) translate claimed address and issue on fabric
// (RULE4) bus side timed by link clock pin
// (RULE5) strap 0 gives 33 MHz, 1 gives 66
// (RULE6) local clock not slower than bus clock
// (RULE7) slave accesses carry byte enables, any width
// (RULE8) local master requests must be word aligned
// (RULE9) six windows: base, mask, translation each
// (RULE10) reset sizes, readahead flags, local starts fixed
// (RULE11) software reprograms window 3 translation first
// (RULE12) mask and translation writable at any time
// (RULE13) bases reached by type 0 configuration accesses
// (RULE14) base: address, readahead, type, indicator fields
// (RULE15) type field always reports memory space
// (RULE16) indicator always reports 32-bit decoding
// (RULE17) base bit host-writable only where mask set
// (RULE18) software sets masks before host sets bases
// (RULE19) mask: writable bits and readahead enable
// (RULE20) masks reachable by local software registers
// (RULE21) translation sets window local start address
// (RULE22) match on masked bits 31 down to 4
// (RULE23) local address ORs kept and translated bits
// (RULE24) strap captured once, held until next reset
module pciw_device
(
	input wire logic sys_clk,
	input wire logic rst,
	pciw_link_if.dev lk,
	input wire logic speed_select_strap,
	output logic speed_mode,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic fab_req,
	output logic [31:0] fab_addr,
	output logic fab_we,
	output logic [3:0] fab_be,
	output logic [31:0] fab_wdata,
	input wire logic fab_ack,
	input wire logic [31:0] fab_rdata,
	input wire logic dsp_req,
	input wire logic [31:0] dsp_addr,
	output logic mst_req,
	output logic [31:0] mst_bus_addr,
	output logic mst_err
);
	typedef enum logic [1:0] {D_IDLE, D_FAB, D_RESP} pciw_dstate_type;
	localparam int LW = 75;

	logic [LW-1:0] ls1_q, ls2_q;
	logic pclk_prev_q, strap1_q, strap2_q, cap_q, cap_d, speed_q, speed_d;
	logic l_pclk, l_frame, l_idsel;
	logic [3:0] l_cmd, l_be;
	logic [31:0] l_addr, l_wdata;
	logic rise;
	logic [27:0] base_q [0:pciw_pkg::NWIN-1];
	logic [27:0] base_d [0:pciw_pkg::NWIN-1];
	logic [31:0] msk_q [0:pciw_pkg::NWIN-1];
	logic [31:0] msk_d [0:pciw_pkg::NWIN-1];
	logic [31:0] trl_q [0:pciw_pkg::NWIN-1];
	logic [31:0] trl_d [0:pciw_pkg::NWIN-1];
	logic [31:0] mbase_q, mbase_d, mmask_q, mmask_d, mbus_q, mbus_d;
	logic [pciw_pkg::NWIN-1:0] whit;
	logic [31:0] wloc [0:pciw_pkg::NWIN-1];
	logic [31:0] base_rd [0:pciw_pkg::NWIN-1];
	pciw_dstate_type st_q, st_d;
	logic ack_q, ack_d, hit_q, hit_d;
	logic [31:0] rdata_q, rdata_d;
	logic freq_q, freq_d, fwe_q, fwe_d;
	logic [3:0] fbe_q, fbe_d;
	logic [31:0] faddr_q, faddr_d, fwd_q, fwd_d;
	logic any_hit, is_cfg, is_mem, base_ok;
	logic [31:0] sel_loc;
	logic [5:0] cidx, pidx;
	logic [2:0] bsel;
	logic pready_q, pready_d, pslverr_q, pslverr_d, pwr;
	logic [31:0] prdata_q, prdata_d;
	logic mreq_q, mreq_d, merr_q, merr_d, in_map;
	logic [31:0] mbadr_q, mbadr_d;

	assign {l_pclk, l_frame, l_idsel, l_cmd, l_be, l_addr, l_wdata} = ls2_q;
	// sys_clk is at least the link rate, so no link edge is missed [RULE6]
	assign rise = l_pclk & ~pclk_prev_q; // [RULE4]

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ls1_q <= '0;
			ls2_q <= '0;
			pclk_prev_q <= 1'b0;
		end
		else
		begin
			ls1_q <= {lk.pclk, lk.frame, lk.idsel, lk.cmd, lk.be, lk.addr, lk.wdata};
			ls2_q <= ls1_q;
			pclk_prev_q <= ls2_q[LW-1];
		end
	end

	// strap flops keep running through reset, so the pin level has settled by the capture edge
	always_ff @(posedge sys_clk)
	begin
		strap1_q <= speed_select_strap;
		strap2_q <= strap1_q;
	end

	// strap is taken on the first edge after release, then frozen
	always_comb
	begin
		cap_d = 1'b1;
		speed_d = cap_q ? speed_q : strap2_q; // [RULE5] [RULE24]
	end

	genvar gi;
	generate
		for (gi = 0; gi < pciw_pkg::NWIN; gi++)
		begin : g_win
			pciw_window u_win
			(
				.bus_addr(l_addr),
				.base(base_q[gi]),
				.mask(msk_q[gi]),
				.trl(trl_q[gi]),
				.hit(whit[gi]),
				.local_addr(wloc[gi])
			);
			// readahead mirrors the mask, type and indicator are constant [RULE14] [RULE15] [RULE16]
			assign base_rd[gi] = {base_q[gi], msk_q[gi][pciw_pkg::READAHEAD_BIT],
				pciw_pkg::SPACE_TYPE_MEM, pciw_pkg::SPACE_IND_32}; // [RULE19]
		end
	endgenerate

	always_comb
	begin
		any_hit = 1'b0;
		sel_loc = 32'h0;
		// lowest numbered window wins on overlap
		for (int i = pciw_pkg::NWIN - 1; i >= 0; i--)
		begin
			if (whit[i])
			begin
				any_hit = 1'b1;
				sel_loc = wloc[i];
			end
		end
		is_mem = (l_cmd == pciw_pkg::CMD_MEM_RD) || (l_cmd == pciw_pkg::CMD_MEM_WR) ||
			(l_cmd == pciw_pkg::CMD_MEM_WRI);
		is_cfg = l_idsel && (l_addr[1:0] == 2'h0) &&
			((l_cmd == pciw_pkg::CMD_CFG_RD) || (l_cmd == pciw_pkg::CMD_CFG_WR)); // [RULE13]
		cidx = l_addr[7:2] - pciw_pkg::CFG_BASE0_IDX;
		base_ok = (l_addr[7:2] >= pciw_pkg::CFG_BASE0_IDX) && (cidx < 6'(pciw_pkg::NWIN));
		bsel = cidx[2:0];
	end

	// link side state machine
	always_comb
	begin
		st_d = st_q;
		ack_d = ack_q;
		hit_d = hit_q;
		rdata_d = rdata_q;
		freq_d = freq_q;
		fwe_d = fwe_q;
		fbe_d = fbe_q;
		faddr_d = faddr_q;
		fwd_d = fwd_q;
		unique case (st_q)
			D_IDLE:
			begin
				if (rise && l_frame)
				begin
					ack_d = 1'b1;
					hit_d = 1'b0;
					rdata_d = 32'h0;
					st_d = D_RESP;
					if (is_cfg)
					begin
						hit_d = 1'b1;
						if (base_ok)
							rdata_d = base_rd[bsel];
					end
					else if (is_mem && any_hit) // [RULE2]
					begin
						ack_d = 1'b0;
						freq_d = 1'b1;
						faddr_d = sel_loc; // [RULE3]
						fwe_d = (l_cmd != pciw_pkg::CMD_MEM_RD);
						fbe_d = l_be; // [RULE7]
						fwd_d = l_wdata;
						st_d = D_FAB;
					end
				end
			end
			D_FAB:
			begin
				if (fab_ack)
				begin
					freq_d = 1'b0;
					ack_d = 1'b1;
					hit_d = 1'b1;
					rdata_d = fwe_q ? 32'h0 : fab_rdata;
					st_d = D_RESP;
				end
			end
			D_RESP:
			begin
				if (!l_frame)
				begin
					ack_d = 1'b0;
					st_d = D_IDLE;
				end
			end
		endcase
	end

	// local registers and APB slave
	always_comb
	begin
		pidx = paddr[7:2];
		pwr = psel && penable && pready_q && pwrite && !pslverr_q;
		base_d = base_q;
		msk_d = msk_q;
		trl_d = trl_q;
		mbase_d = mbase_q;
		mmask_d = mmask_q;
		mbus_d = mbus_q;
		if (st_q == D_IDLE && rise && l_frame && is_cfg && base_ok && l_cmd == pciw_pkg::CMD_CFG_WR)
			base_d[bsel] = (base_q[bsel] & ~msk_q[bsel][31:4]) | (l_wdata[31:4] & msk_q[bsel][31:4]); // [RULE17]
		pready_d = psel && penable && !pready_q;
		pslverr_d = 1'b0;
		prdata_d = 32'h0;
		for (int i = 0; i < pciw_pkg::NWIN; i++)
		begin
			if (pidx == pciw_pkg::IDX_MSK0 + 6'(i))
			begin
				prdata_d = {msk_q[i][31:3], 3'h0};
				if (pwr)
					msk_d[i] = {pwdata[31:3], 3'h0}; // [RULE12] [RULE20]
			end
			if (pidx == pciw_pkg::IDX_TRL0 + 6'(i))
			begin
				prdata_d = {trl_q[i][31:4], 4'h0};
				if (pwr)
					trl_d[i] = {pwdata[31:4], 4'h0}; // [RULE12] [RULE21]
			end
		end
		unique case (pidx)
			pciw_pkg::IDX_MST_BASE: prdata_d = mbase_q;
			pciw_pkg::IDX_MST_MASK: prdata_d = mmask_q;
			pciw_pkg::IDX_MST_BUS: prdata_d = mbus_q;
			pciw_pkg::IDX_STATUS: prdata_d = {29'h0, freq_q, ack_q, speed_q};
			default:
			begin
				if (!(pidx < pciw_pkg::IDX_MSK0 + 6'(pciw_pkg::NWIN)) &&
					!(pidx >= pciw_pkg::IDX_TRL0 && pidx < pciw_pkg::IDX_TRL0 + 6'(pciw_pkg::NWIN)))
					pslverr_d = pready_d;
			end
		endcase
		if (pwr && pidx == pciw_pkg::IDX_MST_BASE)
			mbase_d = pwdata;
		if (pwr && pidx == pciw_pkg::IDX_MST_MASK)
			mmask_d = pwdata;
		if (pwr && pidx == pciw_pkg::IDX_MST_BUS)
			mbus_d = pwdata;
		if (!pready_d)
			prdata_d = 32'h0;
	end

	// local master path
	always_comb
	begin
		in_map = ((dsp_addr ^ mbase_q) & mmask_q) == 32'h0;
		// a misaligned start is refused rather than forwarded [RULE8]
		mreq_d = dsp_req && in_map && (dsp_addr[1:0] == 2'h0); // [RULE1]
		merr_d = dsp_req && !mreq_d;
		mbadr_d = mreq_d ? ((mbus_q & mmask_q) | (dsp_addr & ~mmask_q)) : mbadr_q;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cap_q <= 1'b0;
			speed_q <= pciw_pkg::SPEED_33;
			st_q <= D_IDLE;
			ack_q <= 1'b0;
			hit_q <= 1'b0;
			rdata_q <= 32'h0;
			freq_q <= 1'b0;
			fwe_q <= 1'b0;
			fbe_q <= 4'h0;
			faddr_q <= 32'h0;
			fwd_q <= 32'h0;
			for (int i = 0; i < pciw_pkg::NWIN; i++)
			begin
				base_q[i] <= pciw_pkg::BASE_RST;
				msk_q[i] <= pciw_pkg::MSK_RST[i]; // [RULE9] [RULE10]
				trl_q[i] <= pciw_pkg::TRL_RST[i]; // [RULE10]
			end
			mbase_q <= pciw_pkg::MST_BASE_RST;
			mmask_q <= pciw_pkg::MST_MASK_RST;
			mbus_q <= pciw_pkg::MST_BUS_RST;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
			mreq_q <= 1'b0;
			merr_q <= 1'b0;
			mbadr_q <= 32'h0;
		end
		else
		begin
			cap_q <= cap_d;
			speed_q <= speed_d;
			st_q <= st_d;
			ack_q <= ack_d;
			hit_q <= hit_d;
			rdata_q <= rdata_d;
			freq_q <= freq_d;
			fwe_q <= fwe_d;
			fbe_q <= fbe_d;
			faddr_q <= faddr_d;
			fwd_q <= fwd_d;
			base_q <= base_d;
			msk_q <= msk_d;
			trl_q <= trl_d;
			mbase_q <= mbase_d;
			mmask_q <= mmask_d;
			mbus_q <= mbus_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			mreq_q <= mreq_d;
			merr_q <= merr_d;
			mbadr_q <= mbadr_d;
		end
	end

	assign lk.ack = ack_q;
	assign lk.hit = hit_q;
	assign lk.rdata = rdata_q;
	assign speed_mode = speed_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign fab_req = freq_q;
	assign fab_addr = faddr_q;
	assign fab_we = fwe_q;
	assign fab_be = fbe_q;
	assign fab_wdata = fwd_q;
	assign mst_req = mreq_q;
	assign mst_bus_addr = mbadr_q;
	assign mst_err = merr_q;
endmodule // pciw_device
`default_nettype wire

// >>> core/pciw_host.sv
/*
 pciw_host: bus-side requester that makes the link clock and runs one access at a time.
 assumes: device end answers on the link with a four-phase ack handshake.
*/
`timescale 1ns/1ns
`default_nettype none
module pciw_host
(
	input wire logic sys_clk,
	input wire logic rst,
	pciw_link_if.host lk,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [3:0] cmd_kind,
	input wire logic cmd_idsel,
	input wire logic [31:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	input wire logic [3:0] cmd_be,
	output logic rsp_valid,
	output logic rsp_hit,
	output logic [31:0] rsp_rdata
);
	typedef enum logic [2:0] {H_IDLE, H_ARM, H_WAIT, H_DROP, H_END} pciw_hstate_type;

	pciw_hstate_type st_q, st_d;
	logic [3:0] div_q, div_d;
	logic pclk_q, pclk_d, fall;
	logic [33:0] as1_q, as2_q;
	logic frame_q, frame_d, idsel_q, idsel_d, rdy_q, rdy_d, rv_q, rv_d, rh_q, rh_d;
	logic [3:0] cmd_q, cmd_d, be_q, be_d;
	logic [31:0] addr_q, addr_d, wd_q, wd_d, rd_q, rd_d;
	logic s_ack, s_hit;
	logic [31:0] s_rdata;

	assign {s_ack, s_hit, s_rdata} = as2_q;

	always_comb
	begin
		// link clock divided from sys_clk; frame moves only as it falls, the other request signals load when a command is taken
		fall = pclk_q && (div_q == pciw_pkg::LINK_HALF_CYC - 4'h1);
		div_d = (div_q == pciw_pkg::LINK_HALF_CYC - 4'h1) ? 4'h0 : div_q + 4'h1;
		pclk_d = (div_q == pciw_pkg::LINK_HALF_CYC - 4'h1) ? ~pclk_q : pclk_q;
		st_d = st_q;
		frame_d = frame_q;
		idsel_d = idsel_q;
		cmd_d = cmd_q;
		be_d = be_q;
		addr_d = addr_q;
		wd_d = wd_q;
		rdy_d = rdy_q;
		rv_d = 1'b0;
		rh_d = rh_q;
		rd_d = rd_q;
		unique case (st_q)
			H_IDLE:
			begin
				if (cmd_valid && rdy_q)
				begin
					rdy_d = 1'b0;
					idsel_d = cmd_idsel;
					cmd_d = cmd_kind;
					be_d = cmd_be;
					addr_d = cmd_addr;
					wd_d = cmd_wdata;
					st_d = H_ARM;
				end
			end
			H_ARM:
			begin
				if (fall)
				begin
					frame_d = 1'b1;
					st_d = H_WAIT;
				end
			end
			H_WAIT:
			begin
				if (s_ack)
				begin
					rh_d = s_hit;
					rd_d = s_rdata;
					st_d = H_DROP;
				end
			end
			H_DROP:
			begin
				if (fall)
				begin
					frame_d = 1'b0;
					st_d = H_END;
				end
			end
			H_END:
			begin
				if (!s_ack)
				begin
					rv_d = 1'b1;
					rdy_d = 1'b1;
					st_d = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= H_IDLE;
			div_q <= 4'h0;
			pclk_q <= 1'b0;
			as1_q <= '0;
			as2_q <= '0;
			frame_q <= 1'b0;
			idsel_q <= 1'b0;
			cmd_q <= 4'h0;
			be_q <= 4'h0;
			addr_q <= 32'h0;
			wd_q <= 32'h0;
			rdy_q <= 1'b1;
			rv_q <= 1'b0;
			rh_q <= 1'b0;
			rd_q <= 32'h0;
		end
		else
		begin
			st_q <= st_d;
			div_q <= div_d;
			pclk_q <= pclk_d;
			as1_q <= {lk.ack, lk.hit, lk.rdata};
			as2_q <= as1_q;
			frame_q <= frame_d;
			idsel_q <= idsel_d;
			cmd_q <= cmd_d;
			be_q <= be_d;
			addr_q <= addr_d;
			wd_q <= wd_d;
			rdy_q <= rdy_d;
			rv_q <= rv_d;
			rh_q <= rh_d;
			rd_q <= rd_d;
		end
	end

	assign lk.pclk = pclk_q;
	assign lk.frame = frame_q;
	assign lk.idsel = idsel_q;
	assign lk.cmd = cmd_q;
	assign lk.be = be_q;
	assign lk.addr = addr_q;
	assign lk.wdata = wd_q;
	assign cmd_ready = rdy_q;
	assign rsp_valid = rv_q;
	assign rsp_hit = rh_q;
	assign rsp_rdata = rd_q;
endmodule // pciw_host
`default_nettype wire

// >>> testbench/pciw_props.sv
/*
 pciw_props: assertions on the link between host end and device end.
 assumes: instantiated beside the link interface, on sys_clk and rst.
*/
`timescale 1ns/1ns
`default_nettype none
module pciw_props
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pclk,
	input wire logic frame,
	input wire logic idsel,
	input wire logic [3:0] cmd,
	input wire logic [31:0] addr,
	input wire logic ack,
	input wire logic hit,
	input wire logic [31:0] rdata
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic is_cfg;
	logic is_mem;
	assign is_cfg = idsel && (cmd == pciw_pkg::CMD_CFG_RD || cmd == pciw_pkg::CMD_CFG_WR) && addr[1:0] == 2'h0;
	assign is_mem = cmd == pciw_pkg::CMD_MEM_RD || cmd == pciw_pkg::CMD_MEM_WR || cmd == pciw_pkg::CMD_MEM_WRI;
	sequence cfg_start;
		$rose(frame) && is_cfg;
	endsequence
	sequence answer_up;
		$rose(ack);
	endsequence
	a_cfg_answer: assert property (cfg_start |-> ##[1:40] ack)
		else $error("config access not answered");
	a_cfg_claim: assert property (answer_up and is_cfg |-> hit)
		else $error("config access not claimed");
	a_bad_cmd: assert property (answer_up and !is_mem && !is_cfg |-> !hit)
		else $error("unsupported command claimed");
	a_base_low: assert property (answer_up and is_cfg && !cmd[0] && addr[7:2] inside {[4:9]} |-> rdata[2:0] == 3'h0)
		else $error("base type or indicator bits not zero");
	a_ack_hold: assert property (ack && frame |=> ack && $stable(hit) && $stable(rdata))
		else $error("answer changed while request held");
	a_ack_drop: assert property ($fell(frame) |-> ##[1:16] !ack)
		else $error("answer not withdrawn");
	a_ack_cause: assert property ($rose(ack) |-> frame)
		else $error("answer without request");
	a_req_hold: assert property (frame && !ack |=> frame && $stable(addr) && $stable(cmd))
		else $error("request dropped before answer");
	a_link_clk: assert property ($rose(pclk) |-> ##4 $fell(pclk))
		else $error("link clock high phase wrong");
	cover property (cfg_start ##[1:40] ack);
endmodule // pciw_props
`default_nettype wire

// >>> testbench/pci_slave_window_mapping_tb_top.sv
/*
 bench top: host end and device end joined by the link, driven from APB, fabric and host command ports.
 assumes: package and design files compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module pci_slave_window_mapping_tb_top;
	logic sys_clk, rst, strap, psel, penable, pwrite, pready, pslverr, speed_mode;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, fab_addr, fab_wdata, fab_rdata, dsp_addr, mst_bus_addr;
	logic fab_req, fab_we, fab_ack, dsp_req, mst_req, mst_err;
	logic [3:0] fab_be, cmd_kind, cmd_be;
	logic cmd_valid, cmd_ready, cmd_idsel, rsp_valid, rsp_hit, h_hit, a_err, f_we;
	logic [31:0] cmd_addr, cmd_wdata, rsp_rdata, h_rd, a_rd, f_addr, f_wd;
	logic [3:0] f_be;
	logic [1:0] fdly;
	int error_cnt, num_checks, fab_cnt;
	always #50 sys_clk = ~sys_clk; // sys_clk is faster than the 800 ns link clock
	pciw_link_if lk();
	pciw_device pciw_device_i(.sys_clk, .rst, .lk(lk), .speed_select_strap(strap), .speed_mode, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fab_req, .fab_addr, .fab_we,
		.fab_be, .fab_wdata, .fab_ack, .fab_rdata, .dsp_req, .dsp_addr, .mst_req, .mst_bus_addr, .mst_err);
	pciw_host pciw_host_i(.sys_clk, .rst, .lk(lk), .cmd_valid, .cmd_ready, .cmd_kind, .cmd_idsel,
		.cmd_addr, .cmd_wdata, .cmd_be, .rsp_valid, .rsp_hit, .rsp_rdata);
	pciw_props pciw_props_i(.sys_clk, .rst, .pclk(lk.pclk), .frame(lk.frame), .idsel(lk.idsel),
		.cmd(lk.cmd), .addr(lk.addr), .ack(lk.ack), .hit(lk.hit), .rdata(lk.rdata));
	// fabric slave: answers three cycles late so the device really waits
	always @(posedge sys_clk)
	begin
		fdly <= (fab_req && !fab_ack) ? fdly + 2'h1 : 2'h0;
		fab_ack <= fdly == 2'h2;
		fab_rdata <= fab_addr ^ 32'h5a5a_0000;
		if (fab_req && fab_ack)
		begin
			fab_cnt++;
			f_addr = fab_addr;
			f_we = fab_we;
			f_be = fab_be;
			f_wd = fab_wdata;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
		a_rd = prdata;
		a_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(n >= 50), 32'h0);
	endtask
	task automatic hreq(input logic [3:0] k, input logic sel, input logic [31:0] a, input logic [31:0] wd,
		input logic [3:0] b);
		int n;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_idsel <= sel;
		cmd_addr <= a;
		cmd_wdata <= wd;
		cmd_be <= b;
		n = 0;
		do @(posedge sys_clk); while (cmd_ready !== 1'b1 && ++n < 400);
		cmd_valid <= 1'b0;
		do @(posedge sys_clk); while (rsp_valid !== 1'b1 && ++n < 400);
		h_hit = rsp_hit;
		h_rd = rsp_rdata;
		chk(32'(n >= 400), 32'h0);
	endtask
	task automatic t_reset;
		for (int w = 0; w < 6; w++)
		begin
			apb(1'b0, 6'(w), 32'h0);
			chk(a_rd, pciw_pkg::MSK_RST[w]);
			apb(1'b0, 6'(8 + w), 32'h0);
			chk(a_rd, pciw_pkg::TRL_RST[w]);
		end
		apb(1'b1, 6'h06, 32'hffff_ffff);
		chk(32'(a_err), 32'h1);
		chk(a_rd, 32'h0);
		apb(1'b0, 6'h13, 32'h0);
		chk(a_rd, {31'h0, pciw_pkg::SPEED_66});
		chk(32'(speed_mode), 32'(pciw_pkg::SPEED_66));
		$display("test reset values done");
	endtask
	task automatic t_bases;
		logic [31:0] m;
		for (int w = 0; w < 6; w++)
		begin
			m = pciw_pkg::MSK_RST[w];
			hreq(pciw_pkg::CMD_CFG_WR, 1'b1, 32'h10 + 32'(4 * w), 32'hffff_ffff, 4'h0);
			chk(32'(h_hit), 32'h1);
			hreq(pciw_pkg::CMD_CFG_RD, 1'b1, 32'h10 + 32'(4 * w), 32'h0, 4'hf);
			chk(h_rd, {m[31:4], m[3], 3'h0});
		end
		hreq(pciw_pkg::CMD_CFG_RD, 1'b0, 32'h10, 32'h0, 4'hf);
		chk(32'(h_hit), 32'h0);
		apb(1'b1, 6'h00, 32'hff80_0000);
		hreq(pciw_pkg::CMD_CFG_RD, 1'b1, 32'h10, 32'h0, 4'hf);
		chk(h_rd, 32'hff80_0000);
		$display("test base registers done");
	endtask
	task automatic t_window;
		logic [3:0] kd [3] = '{pciw_pkg::CMD_MEM_RD, pciw_pkg::CMD_MEM_WR, pciw_pkg::CMD_MEM_WRI};
		logic [31:0] a;
		int c;
		apb(1'b1, 6'h08, 32'h0800_0000);
		apb(1'b1, 6'h0b, 32'h0900_0000);
		apb(1'b0, 6'h0b, 32'h0);
		chk(a_rd, 32'h0900_0000);
		hreq(pciw_pkg::CMD_CFG_WR, 1'b1, 32'h10, 32'h1280_0000, 4'hf);
		for (int i = 0; i < 3; i++)
		begin
			a = 32'h1280_abc0 + 32'(i * 5);
			hreq(kd[i], 1'b0, a, 32'h3344_5566 + 32'(i), 4'h1 << i);
			chk(32'(h_hit), 32'h1);
			chk(f_addr, (a & 32'h007f_ffff) | 32'h0800_0000);
			chk({f_we, f_be}, {i != 0, 4'h1 << i});
			if (i == 0)
				chk(h_rd, f_addr ^ 32'h5a5a_0000);
			else
				chk(f_wd, 32'h3344_5566 + 32'(i));
		end
		c = fab_cnt;
		hreq(pciw_pkg::CMD_MEM_RD, 1'b0, 32'h1300_0000, 32'h0, 4'hf);
		chk({31'(fab_cnt - c), h_hit}, 32'h0);
		hreq(4'h2, 1'b0, 32'h1280_0000, 32'h0, 4'hf);
		chk(32'(h_hit), 32'h0);
		$display("test window decode done");
	endtask
	task automatic dreq(input logic [31:0] a, input logic er, input logic [31:0] ea);
		@(posedge sys_clk);
		dsp_req <= 1'b1;
		dsp_addr <= a;
		@(posedge sys_clk);
		dsp_req <= 1'b0;
		@(posedge sys_clk);
		chk({mst_req, mst_err}, {!er, er});
		if (!er)
			chk(mst_bus_addr, ea);
	endtask
	task automatic t_master;
		apb(1'b1, 6'h12, 32'h8000_0000);
		dreq(32'h4123_4560, 1'b0, 32'h8123_4560);
		dreq(32'h5000_0000, 1'b1, 32'h0);
		dreq(32'h4000_0002, 1'b1, 32'h0);
		$display("test master map done");
	endtask
	task automatic t_strap;
		strap <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk(32'(speed_mode), 32'h1);
		rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk(32'(speed_mode), 32'(pciw_pkg::SPEED_33));
		$display("test speed strap done");
	endtask
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#3000000;
		error_cnt++;
		summarize();
	end
	initial
	begin
		{sys_clk, strap, psel, penable, pwrite, paddr, pwdata, dsp_req, dsp_addr} = '0;
		{cmd_valid, cmd_kind, cmd_idsel, cmd_addr, cmd_wdata, cmd_be, fab_ack, fab_rdata, fdly} = '0;
		rst = 1'b1;
		strap = 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		t_reset();
		t_bases();
		t_window();
		t_master();
		t_strap();
		summarize();
	end
endmodule // pci_slave_window_mapping_tb_top
`default_nettype wire
